/* device_status_threshold.v */
// device status registers and first threshold timing register, wishbone
//
// Local design decision: register access over Wishbone.
`include "status_threshold_regs.vh"

module device_status_threshold #(
  parameter ADDR_W = 9,
  parameter WAKE_CYCLES = 16,
  parameter [1:0] REVISION_CODE = 2'h1, // arbitrary value
  parameter [1:0] OPTION_CODE = 2'h3 // arbitrary value
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [ADDR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // fault levels from the analog side, asynchronous
  input wire thermal_shutdown_i,
  input wire io_regulator_over_voltage_i,
  input wire io_regulator_under_voltage_i,
  input wire analog_supply_over_voltage_i,
  input wire analog_supply_under_voltage_i,
  input wire main_power_over_voltage_i,
  input wire main_power_under_voltage_i,
  // crc check results from the checkers, same clock
  input wire threshold_crc_done_i,
  input wire threshold_crc_fail_i,
  input wire user_nvm_crc_done_i,
  input wire user_nvm_crc_fail_i,
  input wire trim_crc_done_i,
  input wire trim_crc_fail_i,
  // state towards the rest of the device
  output reg wakeup_done_o,
  output reg threshold_map_crc_error_o,
  output reg supply_fault_o,
  output reg [3:0] preset_one_point_one_time_o,
  output reg [3:0] preset_one_point_two_delta_o,
  output reg [`TIME_US_W-1:0] point_one_time_us_o,
  output reg [`TIME_US_W-1:0] point_two_delta_us_o
);

  localparam CNT_W = 16;
  localparam [CNT_W-1:0] WAKE_LAST = WAKE_CYCLES - 1;

  // wake-up sequence states, one-hot
  localparam [1:0] WAKE_RUN = 2'b01;
  localparam [1:0] WAKE_DONE = 2'b10;

  // ---------------------------------------------------------------
  // time code decode, shared by both nibbles
  // ---------------------------------------------------------------
  function [`TIME_US_W-1:0] code_to_us;
    input [3:0] code;
    begin
      case (code)
        4'h0: code_to_us = `TIME_US_0;
        4'h1: code_to_us = `TIME_US_1;
        4'h2: code_to_us = `TIME_US_2;
        4'h3: code_to_us = `TIME_US_3;
        4'h4: code_to_us = `TIME_US_4;
        4'h5: code_to_us = `TIME_US_5;
        4'h6: code_to_us = `TIME_US_6;
        4'h7: code_to_us = `TIME_US_7;
        4'h8: code_to_us = `TIME_US_8;
        4'h9: code_to_us = `TIME_US_9;
        4'ha: code_to_us = `TIME_US_10;
        4'hb: code_to_us = `TIME_US_11;
        4'hc: code_to_us = `TIME_US_12;
        4'hd: code_to_us = `TIME_US_13;
        4'he: code_to_us = `TIME_US_14;
        default: code_to_us = `TIME_US_15;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // fault inputs cross into the clock domain
  // ---------------------------------------------------------------
  wire [`ST1_FLAG_W-1:0] fault_async;
  wire [`ST1_FLAG_W-1:0] fault_sync;

  assign fault_async = {
    thermal_shutdown_i,
    io_regulator_over_voltage_i,
    io_regulator_under_voltage_i,
    analog_supply_over_voltage_i,
    analog_supply_under_voltage_i,
    main_power_over_voltage_i,
    main_power_under_voltage_i
  };

  sync_2ff #(
    .WIDTH(`ST1_FLAG_W)
  ) fault_sync_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(fault_async),
    .q_o(fault_sync)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [6:0] word_idx;
  wire req_take;
  wire rd_take;
  wire wr_take;
  reg hit_status_0;
  reg hit_status_1;
  reg hit_timing;

  assign word_idx = adr_i[8:2];
  // a request is taken on the edge that raises ack
  assign req_take = ce_i & cyc_i & stb_i & ~ack_o;
  assign rd_take = req_take & ~we_i;
  assign wr_take = req_take & we_i;

  always @* begin
    hit_status_0 = 1'b0;
    hit_status_1 = 1'b0;
    hit_timing = 1'b0;
    if (word_idx == `IDX_DEVICE_STATUS_0) begin
      hit_status_0 = 1'b1;
    end else if (word_idx == `IDX_DEVICE_STATUS_1) begin
      hit_status_1 = 1'b1;
    end else if (word_idx == `IDX_PRESET_ONE_THR_0) begin
      hit_timing = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // wake-up sequence
  // ---------------------------------------------------------------
  reg [1:0] wake_state;
  reg [CNT_W-1:0] wake_count;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_state <= WAKE_RUN;
      wake_count <= {CNT_W{1'b0}};
      wakeup_done_o <= 1'b0;
    end else if (ce_i) begin
      case (wake_state)
        WAKE_RUN: begin
          if (wake_count == WAKE_LAST) begin
            wake_state <= WAKE_DONE;
            wakeup_done_o <= 1'b1;
          end else begin
            wake_count <= wake_count + 1'b1;
          end
        end
        WAKE_DONE: begin
          wakeup_done_o <= 1'b1;
        end
        default: begin
          wake_state <= WAKE_RUN;
          wake_count <= {CNT_W{1'b0}};
          wakeup_done_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // device_status_0 flags
  // ---------------------------------------------------------------
  reg wake_error;
  reg thr_crc_error;
  reg nvm_crc_error;
  reg trim_crc_error;
  wire early_command;
  wire wake_error_clear;

  // the host is expected to wait; a command before that is recorded
  assign early_command = req_take & ~wakeup_done_o;
  // a read before wake-up is itself early, so it cannot clear
  assign wake_error_clear = rd_take & hit_status_0 & wakeup_done_o;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_error <= `ST0_WAKE_ERR_RST;
      thr_crc_error <= `ST0_THR_CRC_RST;
      nvm_crc_error <= `ST0_NVM_CRC_RST;
      trim_crc_error <= `ST0_TRIM_CRC_RST;
    end else if (ce_i) begin
      if (early_command) begin
        wake_error <= 1'b1;
      end else if (wake_error_clear) begin
        wake_error <= 1'b0;
      end
      if (threshold_crc_done_i) begin
        thr_crc_error <= threshold_crc_fail_i;
      end
      if (user_nvm_crc_done_i) begin
        nvm_crc_error <= user_nvm_crc_fail_i;
      end
      if (trim_crc_done_i) begin
        trim_crc_error <= trim_crc_fail_i;
      end
    end
  end

  wire [7:0] status_0_value;

  assign status_0_value = {
    REVISION_CODE,
    OPTION_CODE,
    wake_error,
    thr_crc_error,
    nvm_crc_error,
    trim_crc_error
  };

  // ---------------------------------------------------------------
  // device_status_1 clear-on-read flags
  // ---------------------------------------------------------------
  reg [`ST1_FLAG_W-1:0] fault_flags;
  reg [`ST1_FLAG_W-1:0] next_fault_flags;
  wire status_1_read;

  assign status_1_read = rd_take & hit_status_1;

  // a fault seen in the read cycle survives the clear
  always @* begin
    next_fault_flags = fault_flags;
    if (status_1_read) begin
      next_fault_flags = {`ST1_FLAG_W{1'b0}};
    end
    next_fault_flags = next_fault_flags | fault_sync;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_flags <= `ST1_RESET;
    end else if (ce_i) begin
      fault_flags <= next_fault_flags;
    end
  end

  wire [7:0] status_1_value;

  assign status_1_value = {1'b0, fault_flags};

  // ---------------------------------------------------------------
  // preset_one_threshold_timing_0, deliberately without reset
  // ---------------------------------------------------------------
  reg [7:0] timing_0;

  always @(posedge clk_i) begin
    if (ce_i && wr_take && hit_timing && sel_i[0]) begin
      timing_0 <= dat_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // read data and acknowledge
  // ---------------------------------------------------------------
  reg [31:0] next_dat;

  always @* begin
    next_dat = `BUS_IDLE_DATA;
    if (hit_status_0) begin
      next_dat[7:0] = status_0_value;
    end else if (hit_status_1) begin
      next_dat[7:0] = status_1_value;
    end else if (hit_timing) begin
      next_dat[7:0] = timing_0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `BUS_IDLE_DATA;
    end else if (ce_i) begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (rd_take) begin
        dat_o <= next_dat;
      end
    end
  end

  // ---------------------------------------------------------------
  // state outputs
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      threshold_map_crc_error_o <= `ST0_THR_CRC_RST;
      supply_fault_o <= 1'b0;
    end else if (ce_i) begin
      threshold_map_crc_error_o <= thr_crc_error;
      supply_fault_o <= |fault_flags;
    end
  end

  // timing outputs follow the register, undefined until first write
  always @(posedge clk_i) begin
    if (ce_i) begin
      preset_one_point_one_time_o <= timing_0[`THR0_T1_HI:`THR0_T1_LO];
      preset_one_point_two_delta_o <= timing_0[`THR0_T2_HI:`THR0_T2_LO];
      point_one_time_us_o <=
        code_to_us(timing_0[`THR0_T1_HI:`THR0_T1_LO]);
      point_two_delta_us_o <=
        code_to_us(timing_0[`THR0_T2_HI:`THR0_T2_LO]);
    end
  end

endmodule // device_status_threshold

/* status_threshold_regs.vh */
// register map, field layout and time codes of the status and threshold bank
`ifndef STATUS_THRESHOLD_REGS_VH
`define STATUS_THRESHOLD_REGS_VH

// register indices; byte address on the bus is four times the index
`define IDX_DEVICE_STATUS_0 7'h4c
`define IDX_DEVICE_STATUS_1 7'h4d
`define IDX_PRESET_ONE_THR_0 7'h5f

// device_status_0 fields
`define ST0_REV_HI 7
`define ST0_REV_LO 6
`define ST0_OPT_HI 5
`define ST0_OPT_LO 4
`define ST0_WAKE_ERR 3
`define ST0_THR_CRC 2
`define ST0_NVM_CRC 1
`define ST0_TRIM_CRC 0

// device_status_0 reset values of the flag bits
`define ST0_WAKE_ERR_RST 1'b0
`define ST0_THR_CRC_RST 1'b1
`define ST0_NVM_CRC_RST 1'b0
`define ST0_TRIM_CRC_RST 1'b0

// device_status_1 fields; bit 7 reserved, reads zero
`define ST1_FLAG_W 7
`define ST1_RESET 7'h00
`define ST1_THERMAL 6
`define ST1_IO_REGULATOR_OVER_VOLTAGE 5
`define ST1_IO_REGULATOR_UNDER_VOLTAGE 4
`define ST1_ANALOG_SUPPLY_OVER_VOLTAGE 3
`define ST1_ANALOG_SUPPLY_UNDER_VOLTAGE 2
`define ST1_MAIN_POWER_OVER_VOLTAGE 1
`define ST1_MAIN_POWER_UNDER_VOLTAGE 0

// preset_one_threshold_timing_0 fields
`define THR0_T1_HI 7
`define THR0_T1_LO 4
`define THR0_T2_HI 3
`define THR0_T2_LO 0

// threshold time code in microseconds
`define TIME_US_W 14
`define TIME_US_0 14'h0064
`define TIME_US_1 14'h00c8
`define TIME_US_2 14'h012c
`define TIME_US_3 14'h0190
`define TIME_US_4 14'h0258
`define TIME_US_5 14'h0320
`define TIME_US_6 14'h03e8
`define TIME_US_7 14'h04b0
`define TIME_US_8 14'h0578
`define TIME_US_9 14'h07d0
`define TIME_US_10 14'h0960
`define TIME_US_11 14'h0c80
`define TIME_US_12 14'h0fa0
`define TIME_US_13 14'h1450
`define TIME_US_14 14'h1900
`define TIME_US_15 14'h1f40

// read value of an unmapped word
`define BUS_IDLE_DATA 32'h0000_0000

`endif

/* sync_2ff.v */
// two flip-flop synchroniser for a group of asynchronous levels
module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // meta feeds only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      meta <= d_i;
      stable <= meta;
    end
  end

  assign q_o = stable;

endmodule // sync_2ff

/* fault_model.sv */
// model of the analog fault sources and nvm crc checkers
module fault_model (
  input wire logic clk_i,
  input wire logic [6:0] lvl_i,
  input wire logic crc_go_i,
  input wire logic [2:0] crc_fail_i,
  output logic [6:0] fault_o,
  output logic [2:0] done_o,
  output logic [2:0] fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fault_o = 7'h00;
    done_o = 3'h0;
    fail_o = 3'h0;
  end
  always @(posedge clk_i) begin
    fault_o <= lvl_i;
    done_o <= {3{crc_go_i}};
    // fail is only meaningful with done, so it wanders otherwise
    fail_o <= crc_go_i ? crc_fail_i : ~fail_o;
  end
endmodule // fault_model

/* dst_properties.sv */
// concurrent checks of bus answer, wake-up and register fields
module dst_properties #(
  parameter ADDR_W = 9,
  parameter WAKE_CYCLES = 16,
  parameter [1:0] REVISION_CODE = 2'h1,
  parameter [1:0] OPTION_CODE = 2'h3
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [ADDR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire wakeup_done_o,
  input wire threshold_map_crc_error_o,
  input wire supply_fault_o,
  input wire [3:0] preset_one_point_one_time_o,
  input wire [3:0] preset_one_point_two_delta_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [6:0] idx = adr_i[ADDR_W-1:2];
  wire rd = ack_o && !we_i;
  int cnt;
  // saturates so a long run cannot wrap into a false match
  always @(posedge clk_i)
    if (rst_i) cnt <= 0;
    else if (ce_i && cnt < 100000) cnt <= cnt + 1;
  sequence s_take;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_wr;
    ack_o && we_i && sel_i[0] && idx == 7'h5f;
  endsequence
  property p_ack_next; s_take |=> ack_o; endproperty
  property p_ack_pulse; ack_o && ce_i |=> !ack_o; endproperty
  property p_ids;
    rd && idx == 7'h4c |-> dat_o[7:4] == {REVISION_CODE, OPTION_CODE};
  endproperty
  property p_hi_zero; rd |-> dat_o[31:8] == 24'h00_0000; endproperty
  property p_rsv; rd && idx == 7'h4d |-> !dat_o[7]; endproperty
  property p_crc_rst; $fell(rst_i) |-> threshold_map_crc_error_o; endproperty
  property p_wake; $rose(wakeup_done_o) |-> cnt == WAKE_CYCLES; endproperty
  property p_wr;
    s_wr |=> preset_one_point_one_time_o == $past(dat_i[7:4]) &&
      preset_one_point_two_delta_o == $past(dat_i[3:0]);
  endproperty
  property p_sticky;
    $fell(supply_fault_o) |-> $past(rd && idx == 7'h4d);
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ids: assert property (p_ids) else $error("bad id codes");
  a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  a_crc_rst: assert property (p_crc_rst) else $error("crc reset");
  a_wake: assert property (p_wake) else $error("wake time");
  a_wr: assert property (p_wr) else $error("timing nibbles");
  a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule // dst_properties
bind device_status_threshold dst_properties #(.ADDR_W(ADDR_W),
  .WAKE_CYCLES(WAKE_CYCLES), .REVISION_CODE(REVISION_CODE),
  .OPTION_CODE(OPTION_CODE)) chk (.*);

/* tb.sv */
// self-checking bench of the status and threshold timing registers
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [1:0] REV = 2'h1; // arbitrary value
  localparam [1:0] OPT = 2'h3; // arbitrary value
  localparam int US[16] = '{100, 200, 300, 400, 600, 800, 1000, 1200,
    1400, 2000, 2400, 3200, 4000, 5200, 6400, 8000};
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [8:0] adr_i = 9'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [6:0] lvl = 7'h00;
  logic go = 0;
  logic [2:0] fail = 3'h0;
  wire [31:0] dat_o;
  wire ack_o, wakeup_done_o, threshold_map_crc_error_o, supply_fault_o;
  wire [3:0] preset_one_point_one_time_o, preset_one_point_two_delta_o;
  wire [13:0] point_one_time_us_o, point_two_delta_us_o;
  wire [6:0] flt;
  wire [2:0] done, cf;
  int num_errors = 0, comparisons = 0;
  fault_model FM (.clk_i(clk_i), .lvl_i(lvl), .crc_go_i(go),
    .crc_fail_i(fail), .fault_o(flt), .done_o(done), .fail_o(cf));
  device_status_threshold #(.REVISION_CODE(REV), .OPTION_CODE(OPT)) DUT (
    .*, .thermal_shutdown_i(flt[6]), .io_regulator_over_voltage_i(flt[5]),
    .io_regulator_under_voltage_i(flt[4]),
    .analog_supply_over_voltage_i(flt[3]),
    .analog_supply_under_voltage_i(flt[2]),
    .main_power_over_voltage_i(flt[1]), .main_power_under_voltage_i(flt[0]),
    .threshold_crc_done_i(done[2]), .threshold_crc_fail_i(cf[2]),
    .user_nvm_crc_done_i(done[1]), .user_nvm_crc_fail_i(cf[1]),
    .trim_crc_done_i(done[0]), .trim_crc_fail_i(cf[0]));
  initial forever #2.5 clk_i = ~clk_i;
  task end_sim;
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one classic cycle; waits for ack however late it comes
  task wb(input logic w, input logic [6:0] i, input logic [7:0] d,
    input logic s, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    dat_i <= {24'h00_0000, d};
    sel_i <= {3'h0, s};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim;
  end
  initial begin
    logic [31:0] q;
    logic [7:0] d;
    int n;
    void'($urandom(32'h5d1103be));
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    // deliberately early, to provoke the wake-up error
    wb(0, 7'h4c, 8'h00, 0, q);
    n = 0;
    while (wakeup_done_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    wb(0, 7'h4c, 8'h00, 0, q);
    chk("status0 early", 32'h0000_007c, q);
    wb(0, 7'h4c, 8'h00, 0, q);
    chk("status0 clean", 32'h0000_0074, q);
    wb(1, 7'h4d, 8'hff, 1, q);
    wb(0, 7'h4d, 8'h00, 0, q);
    chk("status1 reset", 32'h0000_0000, q);
    wb(0, 7'h10, 8'h00, 0, q);
    chk("unmapped", 32'h0000_0000, q);
    for (n = 0; n < 6; n++) begin
      d = n == 0 ? 8'h07 : n == 1 ? 8'h00 : 8'($urandom);
      @(posedge clk_i);
      go <= 1;
      fail <= d[2:0];
      @(posedge clk_i);
      go <= 0;
      repeat (3) @(posedge clk_i);
      wb(0, 7'h4c, 8'h00, 0, q);
      chk("crc bits", {24'h00_0000, REV, OPT, 1'b0, d[2:0]}, q);
      chk("crc out", {31'h0, d[2]}, threshold_map_crc_error_o);
    end
    for (n = 0; n < 7; n++) begin
      @(posedge clk_i);
      lvl <= 7'h01 << n;
      repeat (6) @(posedge clk_i);
      lvl <= 7'h00;
      repeat (6) @(posedge clk_i);
      chk("fault out", 32'h0000_0001, supply_fault_o);
      wb(0, 7'h4d, 8'h00, 0, q);
      chk("status1 flag", 32'h0000_0001 << n, q);
      wb(0, 7'h4d, 8'h00, 0, q);
      chk("status1 cleared", 32'h0000_0000, q);
    end
    for (n = 0; n < 24; n++) begin
      d = n < 16 ? {n[3:0], ~n[3:0]} : 8'($urandom);
      wb(1, 7'h5f, d, 1, q);
      wb(0, 7'h5f, 8'h00, 0, q);
      chk("timing", {24'h00_0000, d}, q);
      chk("point one", {28'h0, d[7:4]}, preset_one_point_one_time_o);
      chk("point one us", US[d[7:4]], point_one_time_us_o);
      chk("point two us", US[d[3:0]], point_two_delta_us_o);
    end
    wb(1, 7'h5f, ~d, 0, q);
    wb(0, 7'h5f, 8'h00, 0, q);
    chk("timing sel low", {24'h00_0000, d}, q);
    end_sim;
  end
endmodule // tb
